// ===== core/rsf_pkg.sv
// constants for the synthesizer frequency control block
package rsf_pkg;
  // register addresses
  localparam logic [6:0] ADDR_AFC_CTRL   = 7'h1e;
  localparam logic [6:0] ADDR_AFC_LIMIT  = 7'h2a;
  localparam logic [6:0] ADDR_AFC_CORR   = 7'h2b;
  localparam logic [6:0] ADDR_RATE_HIGH  = 7'h6e;
  localparam logic [6:0] ADDR_RATE_LOW   = 7'h6f;
  localparam logic [6:0] ADDR_RATE_CTRL  = 7'h70;
  localparam logic [6:0] ADDR_MOD_CTRL   = 7'h71;
  localparam logic [6:0] ADDR_DEV_LOW    = 7'h72;
  localparam logic [6:0] ADDR_OFF_LOW    = 7'h73;
  localparam logic [6:0] ADDR_OFF_HIGH   = 7'h74;
  localparam logic [6:0] ADDR_BAND       = 7'h75;
  localparam logic [6:0] ADDR_HOP_CH     = 7'h79;
  localparam logic [6:0] ADDR_HOP_STEP   = 7'h7a;
  // values after reset
  localparam logic [7:0] RST_AFC_CTRL    = 8'h01;
  localparam logic [7:0] RST_AFC_LIMIT   = 8'h00;
  localparam logic [7:0] RST_RATE_HIGH   = 8'h0a;
  localparam logic [7:0] RST_RATE_LOW    = 8'h3d;
  localparam logic [7:0] RST_RATE_CTRL   = 8'h00;
  localparam logic [7:0] RST_MOD_CTRL    = 8'h00;
  localparam logic [7:0] RST_DEV_LOW     = 8'h20;
  localparam logic [7:0] RST_OFF         = 8'h00;
  localparam logic [7:0] RST_BAND        = 8'h35;
  localparam logic [7:0] RST_HOP         = 8'h00;
  // field positions
  localparam int RATE_SCALE_BIT = 5;
  localparam int AFC_EN_BIT     = 6;
  localparam int GAIN_LSB       = 3;
  localparam int WAIT_LSB       = 0;
  localparam int DEV_MSB_BIT    = 2;
  localparam int HBAND_BIT      = 5;
  localparam logic [1:0] DTMOD_FIFO = 2'h2;
  localparam logic [1:0] MODTYP_NONE = 2'h0;
  // timing
  localparam int CLK_HZ        = 20_000_000;
  localparam int RATE_REF_HZ   = 1_000_000;
  localparam int REF_DIV       = CLK_HZ / RATE_REF_HZ;
  localparam int TUNE_TIME_US  = 5;
  localparam int TUNE_CYCLES   = TUNE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int MEAS_BITS     = 2;
  localparam logic [7:0] AFC_CORR_MAX = 8'h7f;
  // synthesizer states
  typedef enum logic [1:0] {RSF_IDLE, RSF_TUNE, RSF_TX, RSF_RX} rsf_state_t;
endpackage

// ===== core/rsf_freq_ctrl.sv
// synthesizer frequency, offset, afc and tx rate control
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - hop channel or step written in tx/rx: retune, then return to tx/rx
// - tx fifo packet in flight: hop change waits until packet ends
// - peak deviation is nine-bit code times 625 hz in either band
// - deviation msb sits in modulation control, low eight bits in own register
// - ten-bit manual offset code is two's complement signed
// - separate afc and manual offset stores: afc in rx when enabled, manual offset otherwise
// - offsets shift the lo, not the nominal carrier word
// - offset span is +-160 khz high band, +-80 khz low band
// - afc correction frozen after preamble detect for the packet
// - multi-packet rx: afc reset at packet end and reacquires
// - afc pull-in bounded by limiter times band times 625 hz
// - gain shift: 000 full error, each step halves the feedback
// - afc cycle: measure two bits, correct, then settle
// - cycle-wait field sets settle length; 000 gives no correction
// - afc correction readable as eight-bit value
// - tx bit rate is rate word times 1 mhz over 2^(16+5*scale)
// - rate word drives tx timing only
// - band bit one selects high band; zero enables output divide by two
// - hop carrier offset is channel times step in 10 khz units
// - modulation type 00 gives an unmodulated carrier
module rsf_freq_ctrl (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [6:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        tx_req,
  input  wire logic        rx_req,
  input  wire logic        tx_packet_busy,
  input  wire logic        multi_packet,
  input  wire logic        preamble_det,
  input  wire logic        packet_end,
  input  wire logic        rx_bit_tick,
  input  wire logic [7:0]  freq_err,
  output logic      [1:0]  synth_state,
  output logic      [15:0] hop_offset,
  output logic      [8:0]  deviation_code,
  output logic             fm_enable,
  output logic             band_high,
  output logic             lo_div2_en,
  output logic      [9:0]  offset_applied,
  output logic             tx_bit_tick
);

  // register storage
  logic [7:0] afc_ctrl;
  logic [7:0] afc_pull_limit;
  logic [7:0] rate_high;
  logic [7:0] rate_low;
  logic [7:0] rate_ctrl;
  logic [7:0] mod_ctrl;
  logic [7:0] dev_low;
  logic [7:0] off_low;
  logic [1:0] off_high;
  logic [7:0] band_sel;
  logic [7:0] hop_ch;
  logic [7:0] hop_step;

  // control state
  rsf_pkg::rsf_state_t state;
  logic [7:0]  tune_cnt;
  logic [7:0]  hop_ch_used;
  logic [7:0]  hop_step_used;
  logic        hop_pend;
  logic [4:0]  pre_cnt;
  logic        us_tick;
  logic [20:0] rate_acc;
  logic [7:0]  afc_corr;
  logic        afc_frozen;
  logic [4:0]  afc_bit;

  // decoded fields
  logic        hop_wr;
  logic        tx_fifo;
  logic        afc_en;
  logic [2:0]  gain_shift;
  logic [2:0]  cycle_wait;
  logic [4:0]  cycle_len;
  logic [7:0]  afc_lim;
  logic        enter_rx;

  assign hop_wr     = reg_wr && (reg_addr == rsf_pkg::ADDR_HOP_CH ||
                                 reg_addr == rsf_pkg::ADDR_HOP_STEP);
  assign tx_fifo    = mod_ctrl[5:4] == rsf_pkg::DTMOD_FIFO;
  assign afc_en     = afc_ctrl[rsf_pkg::AFC_EN_BIT];
  assign gain_shift = afc_ctrl[rsf_pkg::GAIN_LSB +: 3];
  assign cycle_wait = afc_ctrl[rsf_pkg::WAIT_LSB +: 3];
  assign cycle_len  = 5'(rsf_pkg::MEAS_BITS) + {1'b0, cycle_wait, 1'b0};
  assign afc_lim    = lim_of(afc_pull_limit);
  assign enter_rx   = state == rsf_pkg::RSF_TUNE && tune_cnt == 8'h00 && rx_req && !tx_req;

  // pull-in limit in correction steps: 625 hz is four 156.25 hz steps
  function automatic logic [7:0] lim_of(input logic [7:0] lim);
    logic [9:0] wide;
    wide = {lim, 2'b00};
    lim_of = (wide > 10'(rsf_pkg::AFC_CORR_MAX)) ? rsf_pkg::AFC_CORR_MAX : wide[7:0];
  endfunction

  // add shifted error to correction and clamp to +-limit
  function automatic logic [7:0] afc_step(input logic [7:0] cur, input logic [7:0] err,
                                          input logic [2:0] sh, input logic [7:0] lim);
    logic signed [9:0] sum;
    sum = 10'($signed(cur)) + 10'($signed(err) >>> sh);
    if (sum > $signed({2'b00, lim}))
      afc_step = lim;
    else if (sum < -$signed({2'b00, lim}))
      afc_step = 8'(-$signed({2'b00, lim}));
    else
      afc_step = sum[7:0];
  endfunction

  // register writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      afc_ctrl       <= rsf_pkg::RST_AFC_CTRL;
      afc_pull_limit <= rsf_pkg::RST_AFC_LIMIT;
      rate_high      <= rsf_pkg::RST_RATE_HIGH;
      rate_low       <= rsf_pkg::RST_RATE_LOW;
      rate_ctrl      <= rsf_pkg::RST_RATE_CTRL;
      mod_ctrl       <= rsf_pkg::RST_MOD_CTRL;
      dev_low        <= rsf_pkg::RST_DEV_LOW;
      off_low        <= rsf_pkg::RST_OFF;
      off_high       <= rsf_pkg::RST_OFF[1:0];
      band_sel       <= rsf_pkg::RST_BAND;
      hop_ch         <= rsf_pkg::RST_HOP;
      hop_step       <= rsf_pkg::RST_HOP;
    end else if (ce && reg_wr) begin
      unique case (reg_addr)
        rsf_pkg::ADDR_AFC_CTRL:  afc_ctrl       <= reg_wdata;
        rsf_pkg::ADDR_AFC_LIMIT: afc_pull_limit <= reg_wdata;
        rsf_pkg::ADDR_RATE_HIGH: rate_high      <= reg_wdata;
        rsf_pkg::ADDR_RATE_LOW:  rate_low       <= reg_wdata;
        rsf_pkg::ADDR_RATE_CTRL: rate_ctrl      <= reg_wdata;
        rsf_pkg::ADDR_MOD_CTRL:  mod_ctrl       <= reg_wdata;
        rsf_pkg::ADDR_DEV_LOW:   dev_low        <= reg_wdata;
        rsf_pkg::ADDR_OFF_LOW:   off_low        <= reg_wdata;
        rsf_pkg::ADDR_OFF_HIGH:  off_high       <= reg_wdata[1:0];
        rsf_pkg::ADDR_BAND:      band_sel       <= reg_wdata;
        rsf_pkg::ADDR_HOP_CH:    hop_ch         <= reg_wdata;
        rsf_pkg::ADDR_HOP_STEP:  hop_step       <= reg_wdata;
        default: ;
      endcase
    end
  end

  // registered read data, unmapped reads return zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (ce && reg_rd) begin
      unique case (reg_addr)
        rsf_pkg::ADDR_AFC_CTRL:  reg_rdata <= afc_ctrl;
        rsf_pkg::ADDR_AFC_LIMIT: reg_rdata <= afc_pull_limit;
        rsf_pkg::ADDR_AFC_CORR:  reg_rdata <= afc_corr;
        rsf_pkg::ADDR_RATE_HIGH: reg_rdata <= rate_high;
        rsf_pkg::ADDR_RATE_LOW:  reg_rdata <= rate_low;
        rsf_pkg::ADDR_RATE_CTRL: reg_rdata <= rate_ctrl;
        rsf_pkg::ADDR_MOD_CTRL:  reg_rdata <= mod_ctrl;
        rsf_pkg::ADDR_DEV_LOW:   reg_rdata <= dev_low;
        rsf_pkg::ADDR_OFF_LOW:   reg_rdata <= off_low;
        rsf_pkg::ADDR_OFF_HIGH:  reg_rdata <= {6'h00, off_high};
        rsf_pkg::ADDR_BAND:      reg_rdata <= band_sel;
        rsf_pkg::ADDR_HOP_CH:    reg_rdata <= hop_ch;
        rsf_pkg::ADDR_HOP_STEP:  reg_rdata <= hop_step;
        default:                 reg_rdata <= 8'h00;
      endcase
    end
  end

  // synthesizer state: tune, tx, rx, with automatic retune on hop writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state    <= rsf_pkg::RSF_IDLE;
      tune_cnt <= 8'h00;
    end else if (ce) begin
      unique case (state)
        rsf_pkg::RSF_IDLE: begin
          if (tx_req || rx_req) begin
            state    <= rsf_pkg::RSF_TUNE;
            tune_cnt <= 8'(rsf_pkg::TUNE_CYCLES - 1);
          end
        end
        rsf_pkg::RSF_TUNE: begin
          if (tune_cnt != 8'h00)
            tune_cnt <= tune_cnt - 8'h01;
          else if (tx_req)
            state <= rsf_pkg::RSF_TX;
          else if (rx_req)
            state <= rsf_pkg::RSF_RX;
          else
            state <= rsf_pkg::RSF_IDLE;
        end
        rsf_pkg::RSF_TX: begin
          if (!tx_req) begin
            state <= rsf_pkg::RSF_IDLE;
          end else if ((hop_wr || hop_pend) && !(tx_fifo && tx_packet_busy)) begin
            state    <= rsf_pkg::RSF_TUNE;
            tune_cnt <= 8'(rsf_pkg::TUNE_CYCLES - 1);
          end
        end
        rsf_pkg::RSF_RX: begin
          if (!rx_req) begin
            state <= rsf_pkg::RSF_IDLE;
          end else if (hop_wr) begin
            state    <= rsf_pkg::RSF_TUNE;
            tune_cnt <= 8'(rsf_pkg::TUNE_CYCLES - 1);
          end
        end
      endcase
    end
  end

  // deferred hop request while a fifo packet is on air; a new write wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      hop_pend <= 1'b0;
    else if (ce) begin
      if (state == rsf_pkg::RSF_TX && hop_wr && tx_fifo && tx_packet_busy)
        hop_pend <= 1'b1;
      else if (state != rsf_pkg::RSF_TX || !tx_packet_busy || !tx_fifo)
        hop_pend <= hop_pend && state == rsf_pkg::RSF_TX && tx_req &&
                    tx_fifo && tx_packet_busy;
    end
  end

  // hop settings are taken into the synthesizer only while tuning
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hop_ch_used   <= rsf_pkg::RST_HOP;
      hop_step_used <= rsf_pkg::RST_HOP;
    end else if (ce && state == rsf_pkg::RSF_TUNE) begin
      hop_ch_used   <= hop_ch;
      hop_step_used <= hop_step;
    end
  end

  // frequency words toward the synthesizer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hop_offset     <= 16'h0000;
      deviation_code <= 9'h000;
      fm_enable      <= 1'b0;
      band_high      <= 1'b0;
      lo_div2_en     <= 1'b1;
      synth_state    <= 2'h0;
    end else if (ce) begin
      hop_offset     <= hop_ch_used * hop_step_used;
      deviation_code <= {mod_ctrl[rsf_pkg::DEV_MSB_BIT], dev_low};
      fm_enable      <= mod_ctrl[1:0] != rsf_pkg::MODTYP_NONE;
      band_high      <= band_sel[rsf_pkg::HBAND_BIT];
      lo_div2_en     <= !band_sel[rsf_pkg::HBAND_BIT];
      synth_state    <= state;
    end
  end

  // lo shift from the afc correction or the manual offset register, kept apart from the carrier word
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      offset_applied <= 10'h000;
    else if (ce) begin
      if (state == rsf_pkg::RSF_RX && afc_en)
        offset_applied <= {{2{afc_corr[7]}}, afc_corr};
      else
        offset_applied <= {off_high, off_low};
    end
  end

  // 1 mhz reference tick from the system clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_cnt <= 5'h00;
      us_tick <= 1'b0;
    end else if (ce) begin
      us_tick <= pre_cnt == 5'(rsf_pkg::REF_DIV - 1);
      if (pre_cnt == 5'(rsf_pkg::REF_DIV - 1))
        pre_cnt <= 5'h00;
      else
        pre_cnt <= pre_cnt + 5'h01;
    end
  end

  // tx rate accumulator, carry out at bit 16 or bit 21 by the scale bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rate_acc    <= 21'h000000;
      tx_bit_tick <= 1'b0;
    end else if (ce) begin
      tx_bit_tick <= 1'b0;
      if (state != rsf_pkg::RSF_TX) begin
        rate_acc <= 21'h000000;
      end else if (us_tick) begin
        if (rate_ctrl[rsf_pkg::RATE_SCALE_BIT]) begin
          {tx_bit_tick, rate_acc} <= {1'b0, rate_acc} + {6'h00, rate_high, rate_low};
        end else begin
          {tx_bit_tick, rate_acc[15:0]} <= {1'b0, rate_acc[15:0]} +
                                           {1'b0, rate_high, rate_low};
          rate_acc[20:16] <= 5'h00;
        end
      end
    end
  end

  // preamble freeze, released at packet end or when leaving rx; a detect wins over packet end
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      afc_frozen <= 1'b0;
    else if (ce) begin
      if (state != rsf_pkg::RSF_RX)
        afc_frozen <= 1'b0;
      else if (preamble_det)
        afc_frozen <= 1'b1;
      else if (packet_end)
        afc_frozen <= 1'b0;
    end
  end

  // afc cycle: two measuring bits, correct, then settling bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      afc_bit  <= 5'h00;
      afc_corr <= 8'h00;
    end else if (ce) begin
      if (enter_rx || (state == rsf_pkg::RSF_RX && packet_end && multi_packet)) begin
        afc_bit  <= 5'h00;
        afc_corr <= 8'h00;
      end else if (state == rsf_pkg::RSF_RX && afc_en && !afc_frozen &&
                   cycle_wait != 3'h0 && rx_bit_tick) begin
        if (afc_bit == 5'(rsf_pkg::MEAS_BITS - 1))
          afc_corr <= afc_step(afc_corr, freq_err, gain_shift, afc_lim);
        if (afc_bit == cycle_len - 5'h01)
          afc_bit <= 5'h00;
        else
          afc_bit <= afc_bit + 5'h01;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_hop_retune: assert property (
    ce && state == rsf_pkg::RSF_TX && tx_req && hop_wr && !(tx_fifo && tx_packet_busy)
    |=> state == rsf_pkg::RSF_TUNE ##[1:300] state == rsf_pkg::RSF_TX || !tx_req)
    else $error("hop write in tx did not retune and return");

  chk_tx_defer: assert property (
    ce && state == rsf_pkg::RSF_TX && tx_req && tx_fifo && tx_packet_busy
    |=> state == rsf_pkg::RSF_TX)
    else $error("retune during fifo packet");

  chk_dev_code: assert property (
    ce |=> deviation_code == {$past(mod_ctrl[rsf_pkg::DEV_MSB_BIT]), $past(dev_low)})
    else $error("deviation code mismatch");

  chk_tx_offset: assert property (
    ce && state == rsf_pkg::RSF_TX |=> offset_applied == $past({off_high, off_low}))
    else $error("tx not using manual offset");

  chk_afc_bound: assert property (
    $signed(afc_corr) <= $signed({1'b0, afc_lim}) &&
    $signed(afc_corr) >= -$signed({1'b0, afc_lim}) || $changed(afc_pull_limit))
    else $error("afc correction past pull-in limit");

  chk_afc_freeze: assert property (
    ce && afc_frozen && state == rsf_pkg::RSF_RX && !packet_end |=> $stable(afc_corr))
    else $error("afc moved after preamble");

  chk_mpk_reset: assert property (
    ce && state == rsf_pkg::RSF_RX && packet_end && multi_packet |=> afc_corr == 8'h00)
    else $error("afc not reset at packet end");

  chk_wait_zero: assert property (
    ce && cycle_wait == 3'h0 && !enter_rx && !packet_end |=> $stable(afc_corr))
    else $error("afc corrected with zero wait");

  chk_rx_no_rate: assert property (
    state != rsf_pkg::RSF_TX [*2] |-> !tx_bit_tick)
    else $error("tx rate tick outside tx");

  chk_band_div: assert property (
    ce |=> lo_div2_en == !band_high)
    else $error("divider not opposite to band");

  cov_hop_rx: cover property (state == rsf_pkg::RSF_RX && hop_wr && ce);
  cov_defer: cover property (hop_pend ##1 !hop_pend && state == rsf_pkg::RSF_TUNE);
  cov_afc_step: cover property ($changed(afc_corr) && state == rsf_pkg::RSF_RX);
  cov_tx_tick: cover property (tx_bit_tick);

endmodule

`default_nettype wire

// ===== verif/rsf_host_model.sv
// host model that drives the register port of the frequency control block
`timescale 1ns/1ps
`default_nettype none
module rsf_host_model (
  input  wire logic       clk,
  output logic      [6:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  // idle bus at time zero
  initial begin
    reg_addr  = 7'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // one write cycle; released lines show the inverse so stale data never passes
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  // one read cycle; data is picked up by the bench monitor
  task automatic rd(input logic [6:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
  endtask

  // program a tx bit rate, picking the scale bit and tuning write as a host should
  task automatic set_rate(input int bps);
    logic   scale;
    longint word;
    scale = (bps < 30000);
    word  = (longint'(bps) << (16 + 5 * int'(scale))) / 1000000;
    wr(rsf_pkg::ADDR_RATE_CTRL, scale ? 8'h20 : 8'h00);
    wr(rsf_pkg::ADDR_RATE_HIGH, word[15:8]);
    wr(rsf_pkg::ADDR_RATE_LOW, word[7:0]);
    if (bps > 100000) wr(7'h58, 8'hc0);
  endtask
endmodule
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the synthesizer frequency control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk, rst, ce, reg_wr, reg_rd, tx_req, rx_req, tx_packet_busy;
  logic        multi_packet, preamble_det, packet_end, rx_bit_tick;
  logic        fm_enable, band_high, lo_div2_en, tx_bit_tick, rd_hit;
  logic [6:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, freq_err, v, w, ch, e;
  logic [1:0]  synth_state;
  logic [15:0] hop_offset, lfsr;
  logic [8:0]  deviation_code;
  logic [9:0]  offset_applied;
  logic [7:0]  exp_q[$];
  int          errors, checks, cycles, tick_cnt;

  rsf_host_model i_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd));
  rsf_freq_ctrl i_dut (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_req(tx_req), .rx_req(rx_req), .tx_packet_busy(tx_packet_busy),
    .multi_packet(multi_packet), .preamble_det(preamble_det), .packet_end(packet_end),
    .rx_bit_tick(rx_bit_tick), .freq_err(freq_err), .synth_state(synth_state),
    .hop_offset(hop_offset), .deviation_code(deviation_code), .fm_enable(fm_enable),
    .band_high(band_high), .lo_div2_en(lo_div2_en), .offset_applied(offset_applied),
    .tx_bit_tick(tx_bit_tick));

  // 20 mhz clock
  always #25 clk = ~clk;

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      errors++;
      $display("[ERR] %s exp %0h seen %0h", nm, x, s);
    end
  endtask

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      wrap_up();
    end
  end

  // read monitor: oldest noted value against data after the read edge
  always @(posedge clk) rd_hit <= reg_rd && !rst;
  always @(negedge clk) begin
    if (rd_hit) begin
      if (exp_q.size() == 0) chk("rdata_unnoted", 32'h1, 32'h0);
      else chk("reg_rdata", 32'(reg_rdata), 32'(exp_q.pop_front()));
    end
  end

  // tx bit ticks counted once each
  always @(negedge clk) if (tx_bit_tick === 1'b1) tick_cnt++;

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic rnd8(output logic [7:0] r);
    lfsr = lfsr_next(lfsr);
    r = lfsr[7:0];
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    i_host.rd(a);
  endtask

  task automatic settle();
    repeat (2) @(negedge clk);
  endtask

  task automatic wait_state(input logic [1:0] s, input int lim, input string nm);
    int n;
    n = 0;
    while (synth_state !== s && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk(nm, 32'(synth_state), 32'(s));
  endtask

  // rx bit ticks, one pulse every ten cycles
  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge clk);
      rx_bit_tick = 1'b1;
      @(negedge clk);
      rx_bit_tick = 1'b0;
      repeat (8) @(negedge clk);
    end
  endtask

  task automatic rate_run(input int bps, input int span, input int lo, input int hi);
    i_host.set_rate(bps);
    tick_cnt = 0;
    repeat (span) @(negedge clk);
    chk("tx_tick_count_ok", 32'(tick_cnt >= lo && tick_cnt <= hi), 32'h1);
  endtask

  // main sequence
  initial begin
    clk = 0; rst = 1; ce = 1; tx_req = 0; rx_req = 0; tx_packet_busy = 0;
    multi_packet = 0; preamble_det = 0; packet_end = 0; rx_bit_tick = 0;
    freq_err = 8'h00; errors = 0; checks = 0; cycles = 0; tick_cnt = 0;
    lfsr = 16'h0013; rd_hit = 0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 0;
    @(negedge clk);
    // register values after reset, read-only correction
    rd_chk(rsf_pkg::ADDR_RATE_HIGH, 8'h0a);
    rd_chk(rsf_pkg::ADDR_RATE_LOW, 8'h3d);
    rd_chk(rsf_pkg::ADDR_MOD_CTRL, 8'h00);
    rd_chk(rsf_pkg::ADDR_DEV_LOW, 8'h20);
    rd_chk(rsf_pkg::ADDR_OFF_LOW, 8'h00);
    rd_chk(rsf_pkg::ADDR_OFF_HIGH, 8'h00);
    chk("deviation_code", 32'(deviation_code), 32'h020);
    chk("band_high", 32'(band_high), 32'h1);
    chk("lo_div2_en", 32'(lo_div2_en), 32'h0);
    i_host.wr(rsf_pkg::ADDR_AFC_CORR, 8'h55);
    rd_chk(rsf_pkg::ADDR_AFC_CORR, 8'h00);
    // deviation split and unmodulated carrier
    rnd8(v);
    i_host.wr(rsf_pkg::ADDR_MOD_CTRL, 8'h04);
    i_host.wr(rsf_pkg::ADDR_DEV_LOW, v);
    settle();
    chk("deviation_code", 32'(deviation_code), 32'({1'b1, v}));
    chk("fm_enable", 32'(fm_enable), 32'h0);
    i_host.wr(rsf_pkg::ADDR_MOD_CTRL, 8'h02);
    settle();
    chk("fm_enable", 32'(fm_enable), 32'h1);
    chk("deviation_code", 32'(deviation_code), 32'({1'b0, v}));
    // clock enable low freezes the register file
    ce = 0;
    i_host.wr(rsf_pkg::ADDR_DEV_LOW, ~v);
    ce = 1;
    settle();
    chk("ce_freeze", 32'(deviation_code), 32'({1'b0, v}));
    // signed manual offset, carrier word untouched
    rnd8(v);
    rnd8(w);
    i_host.wr(rsf_pkg::ADDR_OFF_LOW, v);
    i_host.wr(rsf_pkg::ADDR_OFF_HIGH, {6'h00, w[1:0]});
    settle();
    chk("offset_applied", 32'(offset_applied), 32'({w[1:0], v}));
    chk("hop_offset", 32'(hop_offset), 32'h0);
    // low band turns on the output divider
    i_host.wr(rsf_pkg::ADDR_BAND, 8'h15);
    settle();
    chk("band_high", 32'(band_high), 32'h0);
    chk("lo_div2_en", 32'(lo_div2_en), 32'h1);
    i_host.wr(rsf_pkg::ADDR_BAND, 8'h35);
    // hop written while idle is only stored
    rnd8(ch);
    i_host.wr(rsf_pkg::ADDR_HOP_STEP, 8'h07);
    i_host.wr(rsf_pkg::ADDR_HOP_CH, ch);
    repeat (20) @(negedge clk);
    chk("idle_state", 32'(synth_state), 32'(rsf_pkg::RSF_IDLE));
    rx_req = 1;
    wait_state(rsf_pkg::RSF_RX, 300, "rx_entry");
    chk("hop_offset", 32'(hop_offset), 32'(16'(ch) * 16'd7));
    tick_cnt = 0;
    repeat (1000) @(negedge clk);
    chk("rx_tx_ticks", 32'(tick_cnt), 32'h0);
    // hop in rx retunes and comes back
    i_host.wr(rsf_pkg::ADDR_HOP_CH, ch ^ 8'h01);
    wait_state(rsf_pkg::RSF_TUNE, 4, "tune_after_hop");
    wait_state(rsf_pkg::RSF_RX, 150, "rx_after_hop");
    chk("hop_offset", 32'(hop_offset), 32'(16'(ch ^ 8'h01) * 16'd7));
    // afc acquire, clamp, freeze, multi-packet reset, gain, zero wait
    i_host.wr(rsf_pkg::ADDR_AFC_LIMIT, 8'h10);
    i_host.wr(rsf_pkg::ADDR_AFC_CTRL, 8'h41);
    settle();
    chk("afc_start", 32'(offset_applied), 32'h0);
    rnd8(e);
    e = e & 8'h0f;
    freq_err = e;
    ticks(4);
    settle();
    chk("afc_one_cycle", 32'(offset_applied), 32'({2'b00, e}));
    rd_chk(rsf_pkg::ADDR_AFC_CORR, e);
    freq_err = 8'h30;
    ticks(8);
    settle();
    chk("afc_clamp", 32'(offset_applied), 32'h040);
    @(negedge clk);
    preamble_det = 1;
    @(negedge clk);
    preamble_det = 0;
    freq_err = 8'hf0;
    ticks(4);
    chk("afc_frozen", 32'(offset_applied), 32'h040);
    multi_packet = 1;
    packet_end = 1;
    @(negedge clk);
    packet_end = 0;
    settle();
    chk("afc_packet_reset", 32'(offset_applied), 32'h0);
    i_host.wr(rsf_pkg::ADDR_AFC_CTRL, 8'h51);
    freq_err = 8'h20;
    ticks(4);
    settle();
    chk("afc_gain_two", 32'(offset_applied), 32'h008);
    freq_err = 8'hc0;
    ticks(4);
    settle();
    chk("afc_negative", 32'(offset_applied), 32'h3f8);
    rd_chk(rsf_pkg::ADDR_AFC_CORR, 8'hf8);
    i_host.wr(rsf_pkg::ADDR_AFC_CTRL, 8'h40);
    ticks(4);
    chk("afc_wait_zero", 32'(offset_applied), 32'h3f8);
    i_host.wr(rsf_pkg::ADDR_AFC_CTRL, 8'h01);
    settle();
    chk("manual_again", 32'(offset_applied), 32'({w[1:0], v}));
    // tx rate generator at both scales
    rx_req = 0;
    tx_req = 1;
    wait_state(rsf_pkg::RSF_TX, 300, "tx_entry");
    rate_run(250000, 1600, 19, 21);
    rd_chk(rsf_pkg::ADDR_RATE_HIGH, 8'h40);
    rd_chk(7'h58, 8'h00);
    rate_run(10000, 6000, 2, 4);
    chk("tx_offset", 32'(offset_applied), 32'({w[1:0], v}));
    // hop write in direct-mode tx retunes and returns to tx
    i_host.wr(rsf_pkg::ADDR_HOP_CH, ch ^ 8'h01);
    wait_state(rsf_pkg::RSF_TUNE, 4, "tx_tune_after_hop");
    wait_state(rsf_pkg::RSF_TX, 150, "tx_after_hop");
    // fifo packet in flight defers the hop
    i_host.wr(rsf_pkg::ADDR_MOD_CTRL, 8'h22);
    tx_packet_busy = 1;
    i_host.wr(rsf_pkg::ADDR_HOP_CH, 8'h03);
    repeat (40) @(negedge clk);
    chk("deferred_state", 32'(synth_state), 32'(rsf_pkg::RSF_TX));
    chk("deferred_hop", 32'(hop_offset), 32'(16'(ch ^ 8'h01) * 16'd7));
    tx_packet_busy = 0;
    wait_state(rsf_pkg::RSF_TUNE, 6, "tune_after_packet");
    wait_state(rsf_pkg::RSF_TX, 150, "tx_after_packet");
    chk("hop_offset", 32'(hop_offset), 32'h0015);
    wrap_up();
  end
endmodule
`default_nettype wire
